/* File: bench/pvm_host.sv */
// Host bus master model for the video memory port of the sequencer.
// Assumes the bench pulses i_go and holds the command until o_done.
`timescale 1ns/1ps
module pvm_host (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic i_we,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [1:0] i_gap,
  input wire logic i_ack,
  input wire logic [7:0] i_rdata,
  output logic o_req,
  output logic o_we,
  output logic [19:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_done,
  output logic o_ok,
  output logic [7:0] o_q
);
  int n;
  // A request is held until ack is seen, then dropped; after twelve
  // cycles the model gives up so that a refused access cannot hang.
  initial begin
    {o_req, o_we, o_done, o_ok} = 4'h0;
    o_addr = 20'h0;
    o_wdata = 8'h0;
    o_q = 8'h0;
    forever begin
      @(negedge i_mclk);
      if (i_go === 1'b1) begin
        repeat (i_gap) @(posedge i_mclk);
        @(posedge i_mclk);
        o_req <= 1'b1;
        o_we <= i_we;
        o_addr <= i_addr;
        o_wdata <= i_wdata;
        n = 0;
        do begin
          @(negedge i_mclk);
          n++;
        end while (i_ack !== 1'b1 && n < 12);
        o_ok <= i_ack;
        o_q <= i_rdata;
        @(posedge i_mclk);
        // Released address and data lines are inverted so a stale value never looks valid.
        o_req <= 1'b0;
        o_addr <= ~i_addr;
        o_wdata <= ~i_wdata;
        o_done <= 1'b1;
        @(posedge i_mclk);
        o_done <= 1'b0;
      end
    end
  end
endmodule : pvm_host

/* File: bench/tb.sv */
// Self-checking bench for the planar video memory sequencer.
// Assumes pvm_seq as the device and pvm_host as the host bus master.
`timescale 1ns/1ps
module tb;
  import pvm_pkg::*;
  localparam logic [19:0] AL [7] = '{20'h9ffff, 20'ha0000, 20'hafffe,
    20'hb0000, 20'hb7fff, 20'hb8000, 20'hbffff};
  localparam logic [7:0] CKV [8] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h04,
    8'h10, 8'h14, 8'h0d};
  logic clk = 1'b0, srst = 1'b1, rwr = 1'b0, rrd = 1'b0, go = 1'b0;
  logic cwe = 1'b0, attr3 = 1'b0, leg = 1'b0, dv;
  logic [12:0] raddr = 13'h0;
  logic [7:0] rwd = 8'h0, cd = 8'h0, rdat, hq, mwd;
  logic [19:0] ca = 20'h0, maddr;
  logic [1:0] gap = 2'h0;
  logic [15:0] dadr = 16'h0;
  logic req, mwe, ack, done, ok, dotk, ctk, ld, blank, run;
  logic [7:0] mrd;
  logic [31:0] seed = 32'h6b3a;
  int mismatches = 0, n_checks = 0, cyc = 0;

  pvm_seq DUT (.i_mclk(clk), .i_srst(srst), .i_legacy_mode(leg),
    .i_reg_addr(raddr), .i_reg_wr(rwr), .i_reg_rd(rrd), .i_reg_wdata(rwd),
    .o_reg_rdata(rdat), .i_mem_req(req), .i_mem_we(mwe),
    .i_mem_addr(maddr), .i_mem_wdata(mwd), .o_mem_ack(ack), .o_mem_hit(),
    .o_mem_rdata(mrd), .i_disp_addr(dadr), .i_char_attr3(attr3),
    .o_disp_data(), .o_disp_valid(dv), .o_blank(blank), .o_dot_tick(dotk),
    .o_char_tick(ctk), .o_shift_load(ld), .o_seq_running(run));
  pvm_host host (.i_mclk(clk), .i_go(go), .i_we(cwe), .i_addr(ca),
    .i_wdata(cd), .i_gap(gap), .i_ack(ack), .i_rdata(mrd), .o_req(req),
    .o_we(mwe), .o_addr(maddr), .o_wdata(mwd), .o_done(done), .o_ok(ok),
    .o_q(hq));

  // Clock, random display fetch inputs and a cycle ceiling.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    dadr <= seed[15:0];
    attr3 <= seed[16];
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      end_of_test();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // Expected plane byte after one write; mode 1 copies the latch whole.
  function automatic logic [7:0] ep(input int p, input logic [1:0] wm,
      input logic [7:0] d, l, b, input logic [2:0] r, input logic [1:0] f,
      input logic [3:0] s, e);
    logic [7:0] rt, sr, m, a;
    rt = (d >> r) | (d << (4'h8 - r));
    m = b;
    sr = e[p] ? {8{s[p]}} : rt;
    if (wm == 2'h1)
      return l;
    if (wm == 2'h2)
      sr = {8{d[p]}};
    if (wm == 2'h3) begin
      sr = {8{s[p]}};
      m = rt & b;
    end
    a = f == 2'h1 ? sr & l : f == 2'h2 ? sr | l : f == 2'h3 ? sr ^ l : sr;
    return (a & m) | (l & ~m);
  endfunction : ep
  function automatic logic hx(input logic [1:0] mp, input logic [19:0] a);
    case (mp)
      2'h0: return a >= WIN_A0000 && a < WIN_A0000 + WIN_128K;
      2'h1: return a >= WIN_A0000 && a < WIN_A0000 + WIN_64K;
      2'h2: return a >= WIN_B0000 && a < WIN_B0000 + WIN_32K;
      default: return a >= WIN_B8000 && a < WIN_B8000 + WIN_32K;
    endcase
  endfunction : hx
  function automatic logic pu(input int s);
    return s == 0 ? dotk : s == 1 ? ctk : ld;
  endfunction : pu

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Register strobes last one cycle; read data is taken a cycle later.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    rwr <= 1'b1;
    raddr <= a;
    rwd <= d;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(posedge clk);
    rrd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    @(negedge clk);
    d = rdat;
  endtask : rd
  task automatic gc(input logic [3:0] i, input logic [7:0] d);
    wr(GC_IDX_ADDR, {4'h0, i});
    wr(GC_DAT_ADDR, d);
  endtask : gc
  task automatic sq(input logic [4:0] i, input logic [7:0] d);
    wr(SEQ_IDX_ADDR, {3'h0, i});
    wr(SEQ_DAT_ADDR, d);
  endtask : sq
  task automatic mem(input logic w, input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1;
    cwe <= w;
    ca <= a;
    cd <= d;
    gap <= seed[1:0];
    @(posedge clk);
    go <= 1'b0;
    repeat (40) begin
      @(negedge clk);
      if (done === 1'b1)
        break;
    end
  endtask : mem
  // Counts cycles between pulses, after two pulses to let timing settle.
  task automatic gapof(input int s, output int n);
    repeat (3) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (pu(s) !== 1'b1 && n < 300);
    end
  endtask : gapof

  initial begin
    logic [7:0] bs [4];
    logic [7:0] x, d, b, e8, q;
    logic [19:0] a;
    logic [1:0] wm, f;
    logic [2:0] r;
    logic [3:0] s, e, m, c, k;
    int n;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    wr(GC_IDX_ADDR, 8'h08);
    rd(GC_DAT_ADDR, q);
    check(q, 8'hff);
    gc(GC_RD_PLANE, 8'hff);
    rd(GC_DAT_ADDR, q);
    check(q, 8'h03);
    rd(13'h0000, q);
    check(q, 8'h00);
    wr(MISC_WR_ADDR, 8'h02);
    sq(SQ_MEM_MODE, 8'h04);
    $display("test registers done");
    // Random writes in every mode over known plane contents.
    for (int it = 0; it < 24; it++) begin
      seed = nxt(seed);
      a = {4'ha, seed[15:0]};
      gc(GC_ACCESS, 8'h00);
      gc(GC_ROT, 8'h00);
      gc(GC_BITMASK, 8'hff);
      gc(GC_FILL_EN, 8'h00);
      for (int p = 0; p < 4; p++) begin
        seed = nxt(seed);
        bs[p] = seed[7:0];
        sq(SQ_PLANE_MASK, 8'h01 << p);
        mem(1'b1, a, bs[p]);
      end
      mem(1'b0, a, 8'h00);
      seed = nxt(seed);
      {wm, r, f, s, e, m} = seed[18:0];
      {d, b, c, k} = seed[31:8];
      if (wm == 2'h3)
        f = 2'h0;
      gc(GC_FILL, {4'h0, s});
      gc(GC_FILL_EN, {4'h0, e});
      gc(GC_ROT, {3'h0, f, r});
      gc(GC_BITMASK, b);
      sq(SQ_PLANE_MASK, {4'h0, m});
      gc(GC_ACCESS, {6'h0, wm});
      mem(1'b1, a, d);
      check({7'h0, ok}, 8'h01);
      gc(GC_ACCESS, 8'h00);
      e8 = 8'hff;
      for (int p = 0; p < 4; p++) begin
        x = m[p] ? ep(p, wm, d, bs[p], b, r, f, s, e) : bs[p];
        if (k[p])
          e8 &= ~(x ^ {8{c[p]}});
        gc(GC_RD_PLANE, 8'(p));
        mem(1'b0, a, 8'h00);
        check(hq, x);
      end
      gc(GC_CMP, {4'h0, c});
      gc(GC_DONTCARE, {4'h0, k});
      gc(GC_ACCESS, 8'h08);
      mem(1'b0, a, 8'h00);
      check(hq, e8);
    end
    gc(GC_ACCESS, 8'h00);
    $display("test random writes done");
    foreach (CKV[i]) begin
      sq(SQ_CLOCKING, CKV[i]);
      n = (CKV[i][0] ? 8 : 9) * (CKV[i][3] ? 2 : 1);
      gapof(2, x);
      check(8'(x), 8'(n * (CKV[i][4] ? 4 : CKV[i][2] ? 2 : 1)));
      gapof(1, x);
      check(8'(x), 8'(n));
      gapof(0, x);
      check(8'(x), CKV[i][3] ? 8'h02 : 8'h01);
    end
    $display("test clocking done");
    sq(SQ_CLOCKING, 8'h20);
    gapof(1, x);
    check({7'h0, blank}, 8'h01);
    check(8'(x), 8'h09);
    mem(1'b0, 20'ha0000, 8'h00);
    check({7'h0, ok}, 8'h01);
    sq(SQ_CLOCKING, 8'h00);
    repeat (3) @(negedge clk);
    check({7'h0, blank}, 8'h00);
    $display("test blank done");
    // Display share of twenty slots: four of five, or two in legacy mode.
    for (int l = 0; l < 2; l++) begin
      @(posedge clk) leg <= 1'(l);
      sq(SQ_CLOCKING, 8'h02);
      @(negedge clk);
      n = 0;
      repeat (20) @(negedge clk) n += dv;
      check(8'(n), l ? 8'h08 : 8'h10);
    end
    $display("test bandwidth done");
    for (int mp = 0; mp < 4; mp++) begin
      gc(GC_MAP, 8'(mp << 2));
      foreach (AL[j]) begin
        mem(1'b0, AL[j], 8'h00);
        check({7'h0, ok}, {7'h0, hx(2'(mp), AL[j])});
      end
    end
    gc(GC_MAP, 8'h00);
    $display("test windows done");
    sq(SQ_RESET, 8'h00);
    repeat (4) @(negedge clk);
    check({7'h0, run}, 8'h00);
    mem(1'b0, 20'ha0000, 8'h00);
    check({7'h0, ok}, 8'h00);
    sq(SQ_RESET, 8'h03);
    repeat (4) @(negedge clk);
    check({7'h0, run}, 8'h01);
    $display("test halt done");
    end_of_test();
  end
endmodule : tb

/* File: rtl/pvm_pkg.sv */
// Constants for the planar video memory sequencer.
// Assumes a host register port with 13-bit byte offsets and 8-bit data.
package pvm_pkg;
  // Register port byte offsets.
  localparam logic [12:0] MISC_WR_ADDR = 13'h1fc2;
  localparam logic [12:0] SEQ_IDX_ADDR = 13'h1fc4;
  localparam logic [12:0] SEQ_DAT_ADDR = 13'h1fc5;
  localparam logic [12:0] MISC_RD_ADDR = 13'h1fcc;
  localparam logic [12:0] GC_IDX_ADDR = 13'h1fce;
  localparam logic [12:0] GC_DAT_ADDR = 13'h1fcf;
  // Sequencer register indexes.
  localparam logic [4:0] SQ_RESET = 5'h00;
  localparam logic [4:0] SQ_CLOCKING = 5'h01;
  localparam logic [4:0] SQ_PLANE_MASK = 5'h02;
  localparam logic [4:0] SQ_FONT = 5'h03;
  localparam logic [4:0] SQ_MEM_MODE = 5'h04;
  // Graphics controller register indexes.
  localparam logic [3:0] GC_FILL = 4'h0;
  localparam logic [3:0] GC_FILL_EN = 4'h1;
  localparam logic [3:0] GC_CMP = 4'h2;
  localparam logic [3:0] GC_ROT = 4'h3;
  localparam logic [3:0] GC_RD_PLANE = 4'h4;
  localparam logic [3:0] GC_ACCESS = 4'h5;
  localparam logic [3:0] GC_MAP = 4'h6;
  localparam logic [3:0] GC_DONTCARE = 4'h7;
  localparam logic [3:0] GC_BITMASK = 4'h8;
  // Writable bit masks; everything else reads as zero.
  localparam logic [7:0] SEQ_IDX_MASK = 8'h1f;
  localparam logic [7:0] GC_IDX_MASK = 8'h0f;
  localparam logic [7:0] RST_MASK = 8'h03;
  localparam logic [7:0] CLK_MASK = 8'h3f;
  localparam logic [7:0] NIB_MASK = 8'h0f;
  localparam logic [7:0] FONT_MASK = 8'h3f;
  localparam logic [7:0] ROT_MASK = 8'h1f;
  localparam logic [7:0] RDP_MASK = 8'h03;
  localparam logic [7:0] ACC_MASK = 8'h7b;
  // Reset values.
  localparam logic [7:0] RST_INIT = 8'h03;
  localparam logic [7:0] NIB_ONES = 8'h0f;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] ZERO_INIT = 8'h00;
  // Field positions.
  localparam int RST_ASYNC = 0;
  localparam int RST_SYNC = 1;
  localparam int CK_DOT8 = 0;
  localparam int CK_BW = 1;
  localparam int CK_RELOAD2 = 2;
  localparam int CK_HALF = 3;
  localparam int CK_RELOAD4 = 4;
  localparam int CK_BLANK = 5;
  localparam int MM_ALPHA = 0;
  localparam int MM_ODDEVEN = 2;
  localparam int MM_CHAIN4 = 3;
  localparam int AC_RDMODE = 3;
  localparam int AC_OE_READ = 4;
  localparam int MP_GFX = 0;
  localparam int MP_OECHAIN = 1;
  localparam int MISC_PAGE = 5;
  // Character widths and memory slot shares.
  localparam logic [3:0] DOTS_9 = 4'h9;
  localparam logic [3:0] DOTS_8 = 4'h8;
  localparam logic [2:0] SLOTS_PER_ROUND = 3'h5;
  localparam logic [2:0] DISP_SHARE_HI = 3'h4;
  localparam logic [2:0] DISP_SHARE_LO = 3'h2;
  // Host memory windows.
  localparam logic [19:0] WIN_A0000 = 20'ha0000;
  localparam logic [19:0] WIN_B0000 = 20'hb0000;
  localparam logic [19:0] WIN_B8000 = 20'hb8000;
  localparam logic [19:0] WIN_128K = 20'h20000;
  localparam logic [19:0] WIN_64K = 20'h10000;
  localparam logic [19:0] WIN_32K = 20'h08000;
  // Sequencer run state.
  typedef enum logic [2:0] {
    SQS_RUN = 3'b001,
    SQS_STOPPING = 3'b010,
    SQS_HALT = 3'b100
  } pvm_seq_state_t;
endpackage : pvm_pkg

/* File: rtl/pvm_seq.sv */
// Sequencer timing and graphics datapath of a planar video adapter.
// Assumes a host register port, a host memory port held until ack, and a
// display fetch address supplied by the CRT timing logic on this clock.
// Notes on behaviour
// R1: Blank bit stops video, gives host all cycles.
// R2: Reload-fourth bit reloads every fourth character.
// R3: Half-rate bit halves dot and character clocks.
// R4: Alternate-reload bit reloads every other character.
// R5: Legacy bandwidth bit sets display slot share.
// R6: Width bit chooses nine or eight dots.
// R7: Plane mask gates writes, several planes together.
// R8: Font map n sits at block 2(n%4)+n/4.
// R9: Chain four picks plane from address bits.
// R10: Odd/even clear splits planes by address parity.
// R11: Legacy alpha takes B-plane high bits from font.
// R12: Fill bits give all-ones or zeros bytes.
// R13: Fill enable chooses fill value over rotated data.
// R14: Compare read flags bits matching reference colour.
// R15: Logic field passes, ANDs, ORs or XORs.
// R16: Mode zero rotates host data by count.
// R17: Normal read returns plane from read field.
// R18: Read-mode bit picks plane data or compare.
// R19: Write mode selects four paths; legacy three is one.
// R20: Map field selects host memory window.
// R21: Odd/even chain replaces address bit zero.
// R22: Graphics bit bypasses character-generator addressing.
// R23: Reset bits stop sequencer after current cycle.
// R24: Cleared bit-mask bits leave memory unchanged.
// R25: Every-fourth reload beats every-other reload.
// R26: Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
module pvm_seq (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_legacy_mode,
  input wire logic [12:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic [19:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_mem_ack,
  output logic o_mem_hit,
  output logic [7:0] o_mem_rdata,
  input wire logic [15:0] i_disp_addr,
  input wire logic i_char_attr3,
  output logic [31:0] o_disp_data,
  output logic o_disp_valid,
  output logic o_blank,
  output logic o_dot_tick,
  output logic o_char_tick,
  output logic o_shift_load,
  output logic o_seq_running
);
  import pvm_pkg::*;

  // Rotate right by a 3-bit count; shared by both write paths.
  function automatic logic [7:0] rot8(input logic [7:0] d,
                                      input logic [2:0] n);
    logic [15:0] dd;
    dd = {d, d} >> n;
    return dd[7:0];
  endfunction : rot8

  // Font map number to 8KB block index within plane 2.
  function automatic logic [2:0] font_blk(input logic [2:0] n);
    return {n[1:0], n[2]};
  endfunction : font_blk

  logic [7:0] seq_idx, gc_idx, misc;
  logic [7:0] sq_rst, sq_clk, sq_pmask, sq_font, sq_mm;
  logic [7:0] gc_fill, gc_fen, gc_cmp, gc_rot, gc_rdp, gc_acc, gc_map;
  logic [7:0] gc_dc, gc_bmask;
  logic [7:0] plane_mem [0:3][0:65535];
  logic [7:0] latch [0:3];
  pvm_seq_state_t state;
  logic [2:0] slot;
  logic [3:0] dot_cnt;
  logic [1:0] char_cnt;
  logic half_ph;
  logic ack_q;

  // Register writes; masks keep reserved bits at zero.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      seq_idx <= ZERO_INIT;
      gc_idx <= ZERO_INIT;
      misc <= ZERO_INIT;
      sq_rst <= RST_INIT;
      sq_clk <= ZERO_INIT;
      sq_pmask <= NIB_ONES;
      sq_font <= ZERO_INIT;
      sq_mm <= ZERO_INIT;
      gc_fill <= ZERO_INIT;
      gc_fen <= ZERO_INIT;
      gc_cmp <= ZERO_INIT;
      gc_rot <= ZERO_INIT;
      gc_rdp <= ZERO_INIT;
      gc_acc <= ZERO_INIT;
      gc_map <= ZERO_INIT;
      gc_dc <= NIB_ONES;
      gc_bmask <= BYTE_ONES;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        MISC_WR_ADDR: misc <= i_reg_wdata;
        SEQ_IDX_ADDR: seq_idx <= i_reg_wdata & SEQ_IDX_MASK; // R26
        GC_IDX_ADDR: gc_idx <= i_reg_wdata & GC_IDX_MASK; // R26
        SEQ_DAT_ADDR: begin
          case (seq_idx[4:0])
            SQ_RESET: sq_rst <= i_reg_wdata & RST_MASK; // R26
            SQ_CLOCKING: sq_clk <= i_reg_wdata & CLK_MASK;
            SQ_PLANE_MASK: sq_pmask <= i_reg_wdata & NIB_MASK;
            SQ_FONT: sq_font <= i_reg_wdata & FONT_MASK;
            SQ_MEM_MODE: sq_mm <= i_reg_wdata & NIB_MASK;
            default: ;
          endcase
        end
        GC_DAT_ADDR: begin
          case (gc_idx[3:0])
            GC_FILL: gc_fill <= i_reg_wdata & NIB_MASK; // R26
            GC_FILL_EN: gc_fen <= i_reg_wdata & NIB_MASK;
            GC_CMP: gc_cmp <= i_reg_wdata & NIB_MASK;
            GC_ROT: gc_rot <= i_reg_wdata & ROT_MASK;
            GC_RD_PLANE: gc_rdp <= i_reg_wdata & RDP_MASK;
            GC_ACCESS: gc_acc <= i_reg_wdata & ACC_MASK;
            GC_MAP: gc_map <= i_reg_wdata & NIB_MASK;
            GC_DONTCARE: gc_dc <= i_reg_wdata & NIB_MASK;
            GC_BITMASK: gc_bmask <= i_reg_wdata;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // Register read mux; unknown offsets and indexes read zero.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = ZERO_INIT;
    case (i_reg_addr)
      MISC_RD_ADDR: next_rdata = misc;
      SEQ_IDX_ADDR: next_rdata = seq_idx;
      GC_IDX_ADDR: next_rdata = gc_idx;
      SEQ_DAT_ADDR: begin
        case (seq_idx[4:0])
          SQ_RESET: next_rdata = sq_rst;
          SQ_CLOCKING: next_rdata = sq_clk;
          SQ_PLANE_MASK: next_rdata = sq_pmask;
          SQ_FONT: next_rdata = sq_font;
          SQ_MEM_MODE: next_rdata = sq_mm;
          default: next_rdata = ZERO_INIT;
        endcase
      end
      GC_DAT_ADDR: begin
        case (gc_idx[3:0])
          GC_FILL: next_rdata = gc_fill;
          GC_FILL_EN: next_rdata = gc_fen;
          GC_CMP: next_rdata = gc_cmp;
          GC_ROT: next_rdata = gc_rot;
          GC_RD_PLANE: next_rdata = gc_rdp;
          GC_ACCESS: next_rdata = gc_acc;
          GC_MAP: next_rdata = gc_map;
          GC_DONTCARE: next_rdata = gc_dc;
          GC_BITMASK: next_rdata = gc_bmask;
          default: next_rdata = ZERO_INIT;
        endcase
      end
      default: next_rdata = ZERO_INIT;
    endcase
  end

  // Read data is registered so it is stable the cycle after the strobe.
  always_ff @(posedge i_mclk) begin
    if (i_srst)
      o_reg_rdata <= ZERO_INIT;
    else if (i_reg_rd)
      o_reg_rdata <= next_rdata;
  end

  // Either reset bit low halts the sequencer once the slot in flight ends.
  logic stop_req;
  assign stop_req = !sq_rst[RST_ASYNC] || !sq_rst[RST_SYNC];
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= SQS_RUN;
    end else begin
      case (state)
        SQS_RUN: if (stop_req) state <= SQS_STOPPING; // R23
        SQS_STOPPING: state <= SQS_HALT; // R23
        SQS_HALT: if (!stop_req) state <= SQS_RUN;
        default: state <= SQS_HALT;
      endcase
    end
  end
  logic running;
  assign running = (state == SQS_RUN);

  // Memory slots: a round of five, display first, host in the rest.
  logic [2:0] disp_share;
  logic disp_slot, host_slot;
  assign disp_share = (i_legacy_mode && sq_clk[CK_BW]) ? DISP_SHARE_LO
                                                       : DISP_SHARE_HI; // R5
  assign disp_slot = running && !sq_clk[CK_BLANK] && (slot < disp_share); // R1
  assign host_slot = running && !disp_slot;
  always_ff @(posedge i_mclk) begin
    if (i_srst || !running)
      slot <= 3'h0;
    else if (slot == SLOTS_PER_ROUND - 3'h1)
      slot <= 3'h0;
    else
      slot <= slot + 3'h1;
  end

  // Dot, character and reload pacing; all held at zero while halted.
  logic dot_en, char_end, load_now;
  logic [3:0] char_dots;
  assign dot_en = running && (!sq_clk[CK_HALF] || half_ph); // R3
  assign char_dots = sq_clk[CK_DOT8] ? DOTS_8 : DOTS_9; // R6
  assign char_end = dot_en && (dot_cnt == char_dots - 4'h1);
  always_comb begin
    if (sq_clk[CK_RELOAD4])
      load_now = char_end && (char_cnt == 2'h3); // R2 R25
    else if (sq_clk[CK_RELOAD2])
      load_now = char_end && char_cnt[0]; // R4
    else
      load_now = char_end;
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst || !running) begin
      half_ph <= 1'b0;
      dot_cnt <= 4'h0;
      char_cnt <= 2'h0;
    end else begin
      half_ph <= !half_ph;
      if (char_end) begin
        dot_cnt <= 4'h0;
        char_cnt <= char_cnt + 2'h1;
      end else if (dot_en) begin
        dot_cnt <= dot_cnt + 4'h1;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_dot_tick <= 1'b0;
      o_char_tick <= 1'b0;
      o_shift_load <= 1'b0;
      o_blank <= 1'b0;
      o_seq_running <= 1'b0;
    end else begin
      o_dot_tick <= dot_en;
      o_char_tick <= char_end;
      o_shift_load <= load_now;
      o_blank <= sq_clk[CK_BLANK] || !running; // R1
      o_seq_running <= running;
    end
  end

  // Host window decode and plane addressing.
  logic [19:0] win_base, win_size, win_off;
  logic win_hit, host_go, oe_par;
  logic [15:0] paddr;
  logic [3:0] wplanes;
  always_comb begin
    case (gc_map[3:2])
      2'h0: begin win_base = WIN_A0000; win_size = WIN_128K; end // R20
      2'h1: begin win_base = WIN_A0000; win_size = WIN_64K; end
      2'h2: begin win_base = WIN_B0000; win_size = WIN_32K; end
      default: begin win_base = WIN_B8000; win_size = WIN_32K; end
    endcase
    win_off = i_mem_addr - win_base;
    win_hit = (i_mem_addr >= win_base) && (win_off < win_size);
    oe_par = win_off[0];
    if (sq_mm[MM_CHAIN4]) begin
      paddr = {2'h0, win_off[15:2]};
      wplanes = 4'h1 << win_off[1:0]; // R9
    end else if (gc_map[MP_OECHAIN]) begin
      paddr = {win_off[15:1], (gc_map[3:2] == 2'h0) ? win_off[16]
                                                      : misc[MISC_PAGE]}; // R21
      wplanes = 4'hf;
    end else begin
      paddr = win_off[15:0];
      wplanes = 4'hf;
    end
    if (!sq_mm[MM_ODDEVEN] && !sq_mm[MM_CHAIN4])
      wplanes = oe_par ? 4'ha : 4'h5; // R10
    wplanes = wplanes & sq_pmask[3:0]; // R7
  end
  assign host_go = host_slot && i_mem_req && !ack_q && win_hit;
  assign o_mem_hit = win_hit;

  // Write data path, per plane.
  logic [7:0] rot_d, wdat [0:3], bmsk;
  logic [1:0] wmode;
  always_comb begin
    rot_d = rot8(i_mem_wdata, gc_rot[2:0]); // R16
    wmode = gc_acc[1:0];
    if (i_legacy_mode && wmode == 2'h3)
      wmode = 2'h1; // R19
    bmsk = (wmode == 2'h3) ? (rot_d & gc_bmask) : gc_bmask; // R19 R24
    for (int p = 0; p < 4; p++) begin
      case (wmode)
        2'h0: wdat[p] = gc_fen[p] ? {8{gc_fill[p]}} : rot_d; // R12 R13
        2'h2: wdat[p] = {8{i_mem_wdata[p]}};
        2'h3: wdat[p] = {8{gc_fill[p]}};
        default: wdat[p] = latch[p];
      endcase
      if (wmode != 2'h1) begin
        case (gc_rot[4:3])
          2'h1: wdat[p] = wdat[p] & latch[p]; // R15
          2'h2: wdat[p] = wdat[p] | latch[p];
          2'h3: wdat[p] = wdat[p] ^ latch[p];
          default: wdat[p] = wdat[p];
        endcase
      end
      wdat[p] = (wdat[p] & bmsk) | (latch[p] & ~bmsk); // R24
    end
  end

  // Display fetch addresses; font bank feeds planes 2 and 3 in alpha mode.
  logic alpha;
  logic [2:0] fmap;
  logic [15:0] baddr;
  assign alpha = i_legacy_mode ? sq_mm[MM_ALPHA] : !gc_map[MP_GFX]; // R11 R22
  assign fmap = i_char_attr3 ? {sq_font[5], sq_font[3:2]}
                             : {sq_font[4], sq_font[1:0]};
  assign baddr = alpha ? {font_blk(fmap), i_disp_addr[12:0]} // R8 R11
                       : i_disp_addr;

  // Plane memories: host writes and display fetches share the slot round.
  always_ff @(posedge i_mclk) begin
    for (int p = 0; p < 4; p++) begin
      if (host_go && i_mem_we && wplanes[p])
        plane_mem[p][paddr] <= wdat[p]; // R7
    end
  end

  // Host reads refill the latches; display fetches drive the shifter data.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int p = 0; p < 4; p++)
        latch[p] <= ZERO_INIT;
      o_disp_data <= 32'h0;
      o_disp_valid <= 1'b0;
    end else begin
      o_disp_valid <= disp_slot;
      if (host_go && !i_mem_we) begin
        for (int p = 0; p < 4; p++)
          latch[p] <= plane_mem[p][paddr];
      end
      if (disp_slot)
        o_disp_data <= {plane_mem[3][baddr], plane_mem[2][baddr],
                        plane_mem[1][i_disp_addr],
                        plane_mem[0][i_disp_addr]};
    end
  end

  // Host read answer: selected plane or colour compare.
  logic [1:0] rplane;
  logic [7:0] cmp_d, next_mrd;
  always_comb begin
    rplane = gc_acc[AC_OE_READ] ? {gc_rdp[1], oe_par} : gc_rdp[1:0];
    if (sq_mm[MM_CHAIN4])
      rplane = win_off[1:0]; // R9
    for (int b = 0; b < 8; b++) begin
      cmp_d[b] = 1'b1;
      for (int p = 0; p < 4; p++)
        if (gc_dc[p] && (plane_mem[p][paddr][b] != gc_cmp[p]))
          cmp_d[b] = 1'b0; // R14
    end
    next_mrd = gc_acc[AC_RDMODE] ? cmp_d : plane_mem[rplane][paddr]; // R17 R18
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ack_q <= 1'b0;
      o_mem_rdata <= ZERO_INIT;
    end else begin
      ack_q <= host_go;
      if (host_go && !i_mem_we)
        o_mem_rdata <= next_mrd;
    end
  end
  assign o_mem_ack = ack_q;

  // Checks.
  chk_blank_no_fetch: assert property (@(posedge i_mclk) disable iff (i_srst)
    sq_clk[CK_BLANK] |-> ##1 !o_disp_valid) // R1
    else $error("display fetch while blanked");
  chk_reload_fourth: assert property (@(posedge i_mclk) disable iff (i_srst)
    load_now && sq_clk[CK_RELOAD4] |-> char_cnt == 2'h3) // R2 R25
    else $error("reload off the fourth character");
  chk_reload_other: assert property (@(posedge i_mclk) disable iff (i_srst)
    load_now && !sq_clk[CK_RELOAD4] && sq_clk[CK_RELOAD2] |-> char_cnt[0])
    else $error("reload off the second character"); // R4
  chk_half_rate: assert property (@(posedge i_mclk) disable iff (i_srst)
    sq_clk[CK_HALF] && $stable(sq_clk) && o_dot_tick |=> !o_dot_tick) // R3
    else $error("dot tick too fast at half rate");
  chk_char_width: assert property (@(posedge i_mclk) disable iff (i_srst)
    char_end |-> dot_cnt == (sq_clk[CK_DOT8] ? 4'h7 : 4'h8)) // R6
    else $error("character length wrong");
  chk_share_low: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_legacy_mode && sq_clk[CK_BW] && slot >= 3'h2 |-> !disp_slot) // R5
    else $error("display took a host slot");
  chk_stop_bound: assert property (@(posedge i_mclk) disable iff (i_srst)
    running && stop_req |-> ##2 state == SQS_HALT) // R23
    else $error("sequencer did not halt");
  chk_ack_follows: assert property (@(posedge i_mclk) disable iff (i_srst)
    host_go |=> o_mem_ack ##1 !o_mem_ack)
    else $error("memory ack not a single pulse");
  chk_masked_write: assert property (@(posedge i_mclk) disable iff (i_srst)
    host_go && i_mem_we && !sq_pmask[0] |=>
    plane_mem[0][$past(paddr)] == $past(plane_mem[0][paddr])) // R7
    else $error("masked plane was written");
  cov_host_write: cover property (@(posedge i_mclk) host_go && i_mem_we);
  cov_cmp_read: cover property (@(posedge i_mclk)
    host_go && !i_mem_we && gc_acc[AC_RDMODE]);
  cov_halt: cover property (@(posedge i_mclk) state == SQS_HALT);
endmodule : pvm_seq
